// [acsp_cfg.svh]
// Offsets, field positions, reset values and timing counts of the configuration port
`ifndef ACSP_CFG_SVH
`define ACSP_CFG_SVH
// ------------------------------------------------------------
// Frame layout
// ------------------------------------------------------------
`define ACSP_INSTR_LAST 4'd15
`define ACSP_BYTE_LAST 4'd7
`define ACSP_RW_BIT 15
`define ACSP_LEN_HI 14
`define ACSP_LEN_LO 13
// ------------------------------------------------------------
// Device registers
// ------------------------------------------------------------
`define ACSP_REG_PORT_CFG 13'h0000
`define ACSP_REG_PWR 13'h0008
`define ACSP_REG_FMT 13'h0014
`define ACSP_LSB_HI 6
`define ACSP_LSB_LO 1
`define ACSP_SRST_HI 5
`define ACSP_SRST_LO 2
`define ACSP_ADDR16_HI 4
`define ACSP_ADDR16_LO 3
`define ACSP_PWR_BIT 0
`define ACSP_FMT_BIT 0
`define ACSP_PIN_IDLE 3'b010
`define ACSP_STRAP_WAIT 3'd4
// ------------------------------------------------------------
// Host registers and timing
// ------------------------------------------------------------
`define ACSP_HOST_INSTR 4'h0
`define ACSP_HOST_WDATA 4'h4
`define ACSP_HOST_RDATA 4'h8
`define ACSP_HOST_CTRL 4'hc
`define ACSP_MCLK_NS 100
`define ACSP_HALF_NS 1200
`define ACSP_HALF_CYC ((`ACSP_HALF_NS + `ACSP_MCLK_NS - 1) / `ACSP_MCLK_NS)
`endif

// [acsp_pkg.sv]
// Shared types and helpers of the configuration port
package acsp_pkg;
  typedef enum logic [2:0] {DS_INSTR = 3'b001, DS_DATA = 3'b010, DS_DONE = 3'b100} acsp_dev_st_type;
  typedef enum logic [4:0] {HS_IDLE = 5'b00001, HS_LOW = 5'b00010, HS_HIGH = 5'b00100,
                            HS_TAIL = 5'b01000, HS_GAP = 5'b10000} acsp_host_st_type;
  // Bit reversal for least-significant-first ordering
  function automatic logic [7:0] acsp_rev8(input logic [7:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
      r[i] = d[7-i];
    return r;
  endfunction
endpackage

// [acsp_link_if.sv]
// Three-wire link between the serial host and the converter port
`timescale 1ns/1ps
`default_nettype none
interface acsp_link_if;
  logic sclk;
  logic sel_n;
  logic host_sdo;
  logic host_oe;
  logic dev_sdo;
  logic dev_oe;
  logic sdio;
  // Undriven line rests low, so the power-down strap reads as run
  assign sdio = dev_oe ? dev_sdo : (host_oe ? host_sdo : 1'b0);
  modport dev (input sclk, input sel_n, input sdio, output dev_sdo, output dev_oe);
  modport host (output sclk, output sel_n, output host_sdo, output host_oe, input sdio);
endinterface
`default_nettype wire

// [acsp_device.sv]
// Converter end of the three-wire configuration port
// Behaviour
// - Serial activity counts only while select low
// - Frame starts at first clock rise after select falls
// - Select held low streams bytes without end when both length bits are set
// - Select pause at byte boundary keeps position, except in a streamed frame
// - Select high releases data pin to strap use
// - Sixteen instruction bits open every frame
// - Two length bits give the data byte count
// - First instruction bit selects read or write when MSB first, last bit when LSB first
// - Read turns data pin around after instruction
// - Data is whole eight-bit words
// - MSB first at reset, LSB first selectable
// - Host drives clock and select; data pin shared
// - Host keeps lines quiet during critical sampling
// - Without select, pins are straps sensed at power-up
// - Clock strap high gives twos complement coding
// - Data strap high powers the converter down
// - Config bit 5 soft-resets registers, self clearing
`timescale 1ns/1ps
`default_nettype none
`include "acsp_cfg.svh"
module acsp_device
(
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  acsp_link_if.dev  link,
  output var logic  twos_comp_o,
  output var logic  powerdown_o,
  output var logic  lsb_first_o,
  output var logic  strap_mode_o
);
  import acsp_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [2:0]      pin_s1;
  logic [2:0]      pin_s2;
  logic [2:0]      pin_s3;
  logic [2:0]      pin_f;
  logic            sclk_q;
  logic            sel_q;
  logic            sclk_f;
  logic            sel_f;
  logic            sdio_f;
  logic            rise;
  logic            fall;
  logic            sel_up;
  logic            sel_dn;

  // Three stages per pin; a level counts once stages two and three agree
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin_s1 <= `ACSP_PIN_IDLE;
      pin_s2 <= `ACSP_PIN_IDLE;
      pin_s3 <= `ACSP_PIN_IDLE;
      pin_f  <= `ACSP_PIN_IDLE;
      sclk_q <= 1'b0;
      sel_q  <= 1'b1;
    end
    else
    begin
      pin_s1 <= {link.sclk, link.sel_n, link.sdio};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f  <= (~(pin_s2 ^ pin_s3) & pin_s2) | ((pin_s2 ^ pin_s3) & pin_f);
      sclk_q <= pin_f[2];
      sel_q  <= pin_f[1];
    end
  end

  // Edges of the filtered pins; clock edges are dropped while deselected
  assign sclk_f = pin_f[2];
  assign sel_f  = pin_f[1];
  assign sdio_f = pin_f[0];
  assign rise   = sclk_f & ~sclk_q & ~sel_f;
  assign fall   = ~sclk_f & sclk_q & ~sel_f;
  assign sel_up = sel_f & ~sel_q;
  assign sel_dn = ~sel_f & sel_q;

  // ------------------------------------------------------------
  // Frame tracking
  // ------------------------------------------------------------
  acsp_dev_st_type st;
  logic [3:0]      bit_cnt;
  logic [15:0]     shreg;
  logic [15:0]     next_shreg;
  logic            rd_op;
  logic [1:0]      len_left;
  logic            stream;
  logic [12:0]     addr;
  logic [12:0]     next_addr;
  logic            lsb_first;
  logic            pwr;
  logic            fmt;

  // Shift direction follows the ordering bit for both phases
  assign next_shreg = lsb_first ? {sdio_f, shreg[15:1]} : {shreg[14:0], sdio_f};
  assign next_addr  = lsb_first ? addr + 13'h0001 : addr - 13'h0001;

  // Bit counter, instruction decode and byte accounting
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st       <= DS_INSTR;
      bit_cnt  <= 4'd0;
      shreg    <= 16'h0000;
      rd_op    <= 1'b0;
      len_left <= 2'd0;
      stream   <= 1'b0;
      addr     <= 13'h0000;
    end
    else if (sel_up && (st == DS_DONE || bit_cnt[2:0] != 3'd0 || (st == DS_DATA && stream)))
    begin
      // Mid-byte release, finished or streamed frame: next select starts afresh
      st      <= DS_INSTR;
      bit_cnt <= 4'd0;
    end
    else if (rise)
    begin
      // A release at a byte boundary falls through and keeps the position
      shreg <= next_shreg;
      unique case (st)
        DS_INSTR:
        begin
          if (bit_cnt == `ACSP_INSTR_LAST)
          begin
            rd_op    <= next_shreg[`ACSP_RW_BIT];
            len_left <= next_shreg[`ACSP_LEN_HI:`ACSP_LEN_LO];
            stream   <= &next_shreg[`ACSP_LEN_HI:`ACSP_LEN_LO];
            addr     <= next_shreg[12:0];
            st       <= DS_DATA;
            bit_cnt  <= 4'd0;
          end
          else
            bit_cnt <= bit_cnt + 4'd1;
        end
        DS_DATA:
        begin
          if (bit_cnt == `ACSP_BYTE_LAST)
          begin
            bit_cnt <= 4'd0;
            addr    <= next_addr;
            if (!stream)
            begin
              if (len_left == 2'd0)
                st <= DS_DONE;
              else
                len_left <= len_left - 2'd1;
            end
          end
          else
            bit_cnt <= bit_cnt + 4'd1;
        end
        DS_DONE:
          bit_cnt <= bit_cnt;  // Extra clocks ignored until select rises
      endcase
    end
  end

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic            wr_en;
  logic [7:0]      wr_byte;
  logic [7:0]      rd_byte;
  logic [7:0]      tx_order;

  assign wr_en   = rise && st == DS_DATA && bit_cnt == `ACSP_BYTE_LAST && !rd_op;
  assign wr_byte = lsb_first ? next_shreg[15:8] : next_shreg[7:0];

  // Writes land at the last rise of each byte; soft reset wins over the rest
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lsb_first <= 1'b0;
      pwr       <= 1'b0;
      fmt       <= 1'b0;
    end
    else if (wr_en && addr == `ACSP_REG_PORT_CFG)
    begin
      if (wr_byte[`ACSP_SRST_HI] || wr_byte[`ACSP_SRST_LO])
      begin
        lsb_first <= 1'b0;
        pwr       <= 1'b0;
        fmt       <= 1'b0;
      end
      else
        lsb_first <= wr_byte[`ACSP_LSB_HI] | wr_byte[`ACSP_LSB_LO];
    end
    else if (wr_en && addr == `ACSP_REG_PWR)
      pwr <= wr_byte[`ACSP_PWR_BIT];
    else if (wr_en && addr == `ACSP_REG_FMT)
      fmt <= wr_byte[`ACSP_FMT_BIT];
  end

  // Readback; the soft reset bits are never stored, so they read as cleared
  always_comb
  begin
    rd_byte = 8'h00;
    if (addr == `ACSP_REG_PORT_CFG)
    begin
      rd_byte[`ACSP_LSB_HI]    = lsb_first;
      rd_byte[`ACSP_LSB_LO]    = lsb_first;
      rd_byte[`ACSP_ADDR16_HI] = 1'b1;
      rd_byte[`ACSP_ADDR16_LO] = 1'b1;
    end
    else if (addr == `ACSP_REG_PWR)
      rd_byte[`ACSP_PWR_BIT] = pwr;
    else if (addr == `ACSP_REG_FMT)
      rd_byte[`ACSP_FMT_BIT] = fmt;
  end

  assign tx_order = lsb_first ? acsp_rev8(rd_byte) : rd_byte;

  // ------------------------------------------------------------
  // Readback driver
  // ------------------------------------------------------------
  logic [7:0]      tx;
  logic            sdo;
  logic            oe;

  // Bits change after falling edges; a byte is loaded at its first fall
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tx  <= 8'h00;
      sdo <= 1'b0;
      oe  <= 1'b0;
    end
    else if (sel_f)
      oe <= 1'b0;
    else if (sel_dn && st == DS_DATA && rd_op && bit_cnt == 4'd0)
      oe <= 1'b1;  // Resume after a pause with the byte already loaded
    else if (fall)
    begin
      if (st == DS_DATA && rd_op)
      begin
        oe <= 1'b1;
        if (bit_cnt == 4'd0)
        begin
          sdo <= tx_order[7];
          tx  <= {tx_order[6:0], 1'b0};
        end
        else
        begin
          sdo <= tx[7];
          tx  <= {tx[6:0], 1'b0};
        end
      end
      else
        oe <= 1'b0;
    end
  end

  assign link.dev_sdo = sdo;
  assign link.dev_oe  = oe;

  // ------------------------------------------------------------
  // Straps and user outputs
  // ------------------------------------------------------------
  logic [2:0]      strap_cnt;
  logic            strap_done;
  logic            fmt_strap;
  logic            pd_strap;
  logic            spi_mode;

  // Straps caught once the synchronisers have settled after reset
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      strap_cnt  <= 3'd0;
      strap_done <= 1'b0;
      fmt_strap  <= 1'b0;
      pd_strap   <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_cnt <= strap_cnt + 3'd1;
      if (strap_cnt == `ACSP_STRAP_WAIT)
      begin
        strap_done <= 1'b1;
        fmt_strap  <= sclk_f;
        pd_strap   <= sdio_f;
      end
    end
  end

  // Any selection after the straps are caught hands the pins to the serial port for good
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      spi_mode <= 1'b0;
    else if (strap_done && !sel_f)
      spi_mode <= 1'b1;
  end

  // Registered user outputs; straps rule until the port is used
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      twos_comp_o  <= 1'b0;
      powerdown_o  <= 1'b0;
      lsb_first_o  <= 1'b0;
      strap_mode_o <= 1'b1;
    end
    else
    begin
      twos_comp_o  <= spi_mode ? fmt : fmt_strap;
      powerdown_o  <= spi_mode ? pwr : pd_strap;
      lsb_first_o  <= lsb_first;
      strap_mode_o <= ~spi_mode;
    end
  end
endmodule
`default_nettype wire

// [acsp_host.sv]
// Serial host end of the configuration port, driven over Avalon-MM
`timescale 1ns/1ps
`default_nettype none
`include "acsp_cfg.svh"
module acsp_host
(
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output var logic  [31:0] avs_readdata_o,
  output var logic         avs_waitrequest_o,
  acsp_link_if.host        link
);
  import acsp_pkg::*;

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  acsp_host_st_type st;
  logic [15:0]     instr;
  logic [31:0]     wdata;
  logic [31:0]     rdata;
  logic [31:0]     rx;
  logic            lsb_cfg;
  logic            busy;
  logic            wr_go;
  logic            start;
  logic            half;
  logic [2:0]      nbytes;
  logic [47:0]     tx_load;

  assign wr_go = avs_write_i & ~avs_waitrequest_o;
  assign start = wr_go && avs_address_i == `ACSP_HOST_INSTR && !busy;

  // One wait state: answer one edge after the request is seen
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end
    else if ((avs_read_i || avs_write_i) && avs_waitrequest_o)
    begin
      avs_waitrequest_o <= 1'b0;
      unique case (avs_address_i)
        `ACSP_HOST_INSTR: avs_readdata_o <= {16'h0000, instr};
        `ACSP_HOST_WDATA: avs_readdata_o <= wdata;
        `ACSP_HOST_RDATA: avs_readdata_o <= rdata;
        `ACSP_HOST_CTRL:  avs_readdata_o <= {30'h0000_0000, busy, lsb_cfg};
        default:          avs_readdata_o <= 32'h0000_0000;
      endcase
    end
    else
      avs_waitrequest_o <= 1'b1;
  end

  // Write data and ordering; ordering is frozen while a frame runs
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wdata   <= 32'h0000_0000;
      lsb_cfg <= 1'b0;
    end
    else if (wr_go && avs_address_i == `ACSP_HOST_WDATA)
      wdata <= avs_writedata_i;
    else if (wr_go && avs_address_i == `ACSP_HOST_CTRL && !busy)
      lsb_cfg <= avs_writedata_i[0];
  end

  // Serial image of a frame: instruction, then data bytes, first byte lowest
  assign nbytes  = {1'b0, avs_writedata_i[`ACSP_LEN_HI:`ACSP_LEN_LO]} + 3'd1;
  assign tx_load = lsb_cfg ?
    {acsp_rev8(avs_writedata_i[7:0]), acsp_rev8(avs_writedata_i[15:8]), acsp_rev8(wdata[7:0]),
     acsp_rev8(wdata[15:8]), acsp_rev8(wdata[23:16]), acsp_rev8(wdata[31:24])} :
    {avs_writedata_i[15:0], wdata[7:0], wdata[15:8], wdata[23:16], wdata[31:24]};

  // ------------------------------------------------------------
  // Serial engine
  // ------------------------------------------------------------
  logic [47:0]     tx;
  logic [5:0]      nbits;
  logic [5:0]      bit_i;
  logic [5:0]      k;
  logic [3:0]      tmr;
  logic            rd_op;
  logic [2:0]      sd_s;
  logic            sd_f;

  assign half = tmr == 4'(`ACSP_HALF_CYC - 1);
  assign k    = bit_i - 6'd16;

  // Clock made by division; data set at each fall, sampled at each rise
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st            <= HS_IDLE;
      instr         <= 16'h0000;
      tx            <= 48'h0;
      nbits         <= 6'd0;
      bit_i         <= 6'd0;
      tmr           <= 4'd0;
      rd_op         <= 1'b0;
      busy          <= 1'b0;
      link.sclk     <= 1'b0;
      link.sel_n    <= 1'b1;
      link.host_sdo <= 1'b0;
      link.host_oe  <= 1'b0;
    end
    else
    begin
      tmr <= (half || st == HS_IDLE) ? 4'd0 : tmr + 4'd1;
      unique case (st)
        HS_IDLE:
          if (start)
          begin
            instr         <= avs_writedata_i[15:0];
            rd_op         <= avs_writedata_i[`ACSP_RW_BIT];
            nbits         <= 6'd16 + {nbytes, 3'b000};
            bit_i         <= 6'd0;
            busy          <= 1'b1;
            link.sel_n    <= 1'b0;
            link.host_oe  <= 1'b1;
            link.host_sdo <= tx_load[47];
            tx            <= {tx_load[46:0], 1'b0};
            st            <= HS_LOW;
          end
        HS_LOW:
          if (half)
          begin
            link.sclk <= 1'b1;
            st        <= HS_HIGH;
          end
        HS_HIGH:
          if (half)
          begin
            link.sclk <= 1'b0;
            if (bit_i == nbits - 6'd1)
              st <= HS_TAIL;
            else
            begin
              bit_i         <= bit_i + 6'd1;
              link.host_sdo <= tx[47];
              tx            <= {tx[46:0], 1'b0};
              if (rd_op && bit_i == 6'd15)
                link.host_oe <= 1'b0;
              st <= HS_LOW;
            end
          end
        HS_TAIL:
          if (half)
          begin
            link.sel_n   <= 1'b1;
            link.host_oe <= 1'b0;
            st           <= HS_GAP;
          end
        HS_GAP:
          if (half)
          begin
            busy <= 1'b0;
            st   <= HS_IDLE;
          end
      endcase
    end
  end

  // Data line passes three stages; a level counts once stages two and three agree
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sd_s <= 3'b000;
      sd_f <= 1'b0;
    end
    else
    begin
      sd_s <= {sd_s[1:0], link.sdio};
      if (sd_s[1] == sd_s[2])
        sd_f <= sd_s[2];
    end
  end

  // Readback bits collected at each rise, then published at frame end
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rx    <= 32'h0000_0000;
      rdata <= 32'h0000_0000;
    end
    else if (start)
      rx <= 32'h0000_0000;
    else if (st == HS_LOW && half && rd_op && bit_i >= 6'd16)
      rx[{k[4:3], lsb_cfg ? k[2:0] : ~k[2:0]}] <= sd_f;
    else if (st == HS_TAIL && half && rd_op)
      rdata <= rx;
  end
endmodule
`default_nettype wire

// [acsp_assertions.sv]
// Checker of the three-wire link between serial host and converter port
`timescale 1ns/1ps
`default_nettype none
module acsp_checker
(
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  input  wire logic sclk,
  input  wire logic sel_n,
  input  wire logic host_oe,
  input  wire logic dev_sdo,
  input  wire logic dev_oe
);
  logic [7:0] rises;
  logic       sclk_q;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  // Rising clock count in a frame; cleared while select is high
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sclk_q <= 1'b0;
      rises  <= 8'h00;
    end
    else
    begin
      sclk_q <= sclk;
      if (sel_n)
        rises <= 8'h00;
      else if (sclk && !sclk_q)
        rises <= rises + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Framing and turnaround steps
  // ------------------------------------------------------------
  sequence quiet_clock;
    !sclk [*8];
  endsequence
  sequence held_high;
    sclk [*8];
  endsequence

  sel_idle_clock_a: assert property (sel_n |-> !sclk) else $error("clock moves while deselected");
  frame_setup_a: assert property ($fell(sel_n) |-> quiet_clock) else $error("clock rises too soon");
  half_period_a: assert property ($rose(sclk) |-> held_high) else $error("clock high too short");
  no_fight_a: assert property (!(dev_oe && host_oe)) else $error("both ends drive data");
  released_idle_a: assert property (sel_n [*8] |-> !dev_oe) else $error("data held while deselected");
  turn_point_a: assert property ($rose(dev_oe) |-> rises == 8'd16 && !sclk) else $error("turnaround misplaced");
  turn_time_a: assert property ($fell(host_oe) && rises == 8'd16 |-> ##[1:8] dev_oe) else $error("no readback");
  readback_edge_a: assert property (dev_oe && $past(dev_oe) && $changed(dev_sdo) |-> !sclk)
    else $error("readback changed while clock high");
  whole_bytes_a: assert property ($rose(sel_n) |-> rises[2:0] == 3'h0 && rises >= 8'd24 && rises <= 8'd48)
    else $error("frame not whole bytes");
endmodule
`default_nettype wire

// [test_adc_config_serial_port.sv]
// Self-checking bench: host and converter ends, plus a bench-driven strap link
`timescale 1ns/1ps
`default_nettype none
module test_adc_config_serial_port;
  logic        mclk_i;
  logic        rst_b_i;
  logic [3:0]  av_a;
  logic        av_rd;
  logic        av_wr;
  logic [31:0] av_wd;
  logic [31:0] av_q;
  logic        av_wait;
  logic        tw1, pd1, lsb1, st1, tw2, pd2, st2;
  logic [31:0] rd;
  int          n_mismatch;
  int          total_checks;
  int          cycles;

  acsp_link_if link1 ();
  acsp_link_if link2 ();

  acsp_host acsp_host_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .avs_address_i(av_a), .avs_read_i(av_rd),
    .avs_write_i(av_wr), .avs_writedata_i(av_wd), .avs_readdata_o(av_q), .avs_waitrequest_o(av_wait),
    .link(link1));
  acsp_device acsp_device_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .link(link1), .twos_comp_o(tw1),
    .powerdown_o(pd1), .lsb_first_o(lsb1), .strap_mode_o(st1));
  // Second converter end, driven by the bench only
  acsp_device strap_acsp_device_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .link(link2), .twos_comp_o(tw2),
    .powerdown_o(pd2), .lsb_first_o(), .strap_mode_o(st2));
  acsp_checker acsp_checker_i (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .sclk(link1.sclk), .sel_n(link1.sel_n),
    .host_oe(link1.host_oe), .dev_sdo(link1.dev_sdo), .dev_oe(link1.dev_oe));

  // ------------------------------------------------------------
  // Clock, watchdog and reporting
  // ------------------------------------------------------------
  initial
  begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  // About ten frames fit well inside this ceiling
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // ------------------------------------------------------------
  // Avalon master; request held until waitrequest is seen low
  // ------------------------------------------------------------
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    av_a <= a;
    av_wd <= d;
    av_wr <= 1'b1;
    do @(posedge mclk_i); while (av_wait !== 1'b0);
    av_wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    av_a <= a;
    av_rd <= 1'b1;
    do @(posedge mclk_i); while (av_wait !== 1'b0);
    d = av_q;
    av_rd <= 1'b0;
  endtask

  // One whole frame: data, instruction, wait for busy to clear
  task automatic xfer(input logic [15:0] ins, input logic [31:0] wd, output logic [31:0] q);
    logic [31:0] s;
    bus_wr(4'h4, wd);
    bus_wr(4'h0, {16'h0000, ins});
    do bus_rd(4'hc, s); while (s[1] !== 1'b0);
    bus_rd(4'h8, q);
  endtask

  // Bench-made 800 ns link clock, MSB first; stands low between frames
  task automatic bb_send(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      link2.host_sdo <= v[i];
      repeat (4) @(posedge mclk_i);
      link2.sclk <= 1'b1;
      repeat (4) @(posedge mclk_i);
      link2.sclk <= 1'b0;
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {av_a, av_rd, av_wr, av_wd} = '0;
    {n_mismatch, total_checks, cycles} = '0;
    link2.sclk = 1'b1;
    link2.sel_n = 1'b1;
    link2.host_sdo = 1'b1;
    link2.host_oe = 1'b1;
    rst_b_i = 1'b0;
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (10) @(posedge mclk_i);
    chk({st1, tw1, pd1, lsb1}, 32'h8);
    chk({st2, tw2, pd2}, 32'h7);
    bb_send(16'h00c3, 8);
    repeat (8) @(posedge mclk_i);
    chk({st2, tw2, pd2, link2.dev_oe}, 32'he);
    link2.sel_n <= 1'b0;
    repeat (4) @(posedge mclk_i);
    bb_send(16'h0014, 16);
    repeat (4) @(posedge mclk_i);
    link2.sel_n <= 1'b1;
    link2.host_sdo <= 1'b1;
    repeat (8) @(posedge mclk_i);
    link2.sel_n <= 1'b0;
    repeat (4) @(posedge mclk_i);
    // Byte after the pause must land, or the format stays at its reset value
    bb_send(16'h0001, 8);
    repeat (4) @(posedge mclk_i);
    link2.sel_n <= 1'b1;
    link2.host_sdo <= 1'b1;
    repeat (10) @(posedge mclk_i);
    chk({st2, tw2}, 32'h1);
    bus_rd(4'h6, rd);
    chk(rd, 32'h0);
    xfer(16'h0014, 32'h1, rd);
    chk({st1, tw1}, 32'h1);
    xfer(16'h8014, 32'h0, rd);
    chk(rd[7:0], 32'h1);
    xfer(16'h0008, 32'h1, rd);
    chk(pd1, 32'h1);
    xfer(16'ha001, 32'h0, rd);
    chk(rd[15:0], 32'h1800);
    xfer(16'he003, 32'h0, rd);
    chk(rd, 32'h18000000);
    xfer(16'h0000, 32'h42, rd);
    chk(lsb1, 32'h1);
    bus_wr(4'hc, 32'h1);
    xfer(16'h8000, 32'h0, rd);
    chk(rd[7:0], 32'h5a);
    xfer(16'h0000, 32'h24, rd);
    chk({lsb1, pd1, tw1}, 32'h0);
    bus_wr(4'hc, 32'h0);
    xfer(16'h8000, 32'h0, rd);
    chk(rd[7:0], 32'h18);
    tally_and_finish();
  end
endmodule
`default_nettype wire
